// ### pwmpb_pkg.sv
package pwmpb_pkg;
	typedef enum logic [1:0] {
		PWMPB_MODE_COMPL = 2'b00,
		PWMPB_MODE_REDUN = 2'b01,
		PWMPB_MODE_PUSHPULL = 2'b10,
		PWMPB_MODE_INDEP = 2'b11
	} pwmpb_mode_type;

	typedef enum logic [0:0] {
		PWMPB_IDLE = 1'b0,
		PWMPB_BLANKING = 1'b1
	} pwmpb_state_type;
endpackage

// ### pwmpb_regs.svh
`ifndef PWMPB_REGS_SVH
`define PWMPB_REGS_SVH

// ==========================================
// register offsets
`define PWMPB_ADDR_PHASE 4'h0
`define PWMPB_ADDR_BLANK 4'h2
`define PWMPB_ADDR_CTRL 4'h4
`define PWMPB_ADDR_STAT 4'h6

// ==========================================
// reset values
`define PWMPB_PHASE_RST 16'h0000
`define PWMPB_BLANK_RST 16'h0000
`define PWMPB_CTRL_RST 16'h0000

// ==========================================
// blanking control fields
`define PWMPB_HRISE_BIT 15
`define PWMPB_HFALL_BIT 14
`define PWMPB_LRISE_BIT 13
`define PWMPB_LFALL_BIT 12
`define PWMPB_FLTEN_BIT 11
`define PWMPB_CLEN_BIT 10
`define PWMPB_DUR_MSB 9
`define PWMPB_DUR_LSB 3
`define PWMPB_BLANK_MASK 16'hFFF8

// ==========================================
// generator control fields
`define PWMPB_ITB_BIT 2
`define PWMPB_MODE_MSB 1
`define PWMPB_MODE_LSB 0
`define PWMPB_CTRL_MASK 16'h0007

// ==========================================
// timing: step in picoseconds, clock period in picoseconds
`define PWMPB_STEP_PS 8320
`define PWMPB_CLK_PS 40000
// one step is shorter than a clock: round each step up to a cycle minimum
`define PWMPB_STEP_CYC (((`PWMPB_STEP_PS) + (`PWMPB_CLK_PS) - 1) / (`PWMPB_CLK_PS))

`endif

// ### pwmpb_stage.sv
// ========
// switch-on spike model
module pwmpb_stage #(parameter int SPIKE = 2) (
	input logic i_clk,
	input logic i_high,
	output logic o_spike
);
	timeunit 1ns;
	timeprecision 1ps;
	bit high_reg;
	int cnt_reg;
	// both sensors ring at high-side turn-on, the hazard blanking hides
	always_ff @(posedge i_clk) begin
		high_reg <= i_high;
		if (i_high && !high_reg)
			cnt_reg <= SPIKE;
		else if (cnt_reg > 0)
			cnt_reg <= cnt_reg - 1;
	end
	assign o_spike = cnt_reg != 0;
endmodule

// ### pwmpb_sva.sv
// ========
// port checks
module pwmpb_sva (
	input logic i_mclk,
	input logic i_nrst,
	input logic [3:0] i_addr,
	input logic i_rd,
	input logic [15:0] o_rdata,
	input logic i_pwm_high_output,
	input logic i_pwm_low_output,
	input logic i_fault,
	input logic o_fault,
	input logic i_current_limit,
	input logic o_current_limit,
	input logic o_blanking,
	input logic o_independent_time_base_select,
	input logic [1:0] o_output_mode_select,
	input logic [15:0] o_high_phase,
	input logic [15:0] o_low_phase,
	input logic [15:0] o_high_period,
	input logic [15:0] o_low_period,
	input logic o_high_phase_valid,
	input logic o_low_phase_valid,
	input logic o_high_period_valid,
	input logic o_low_period_valid
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("rdata not idle");
	a_blank_rsvd: assert property ($past(i_rd) &&
		$past(i_addr) == 4'h2 |-> o_rdata[2:0] == 3'h0) else $error("rsvd set");
	a_phase_pair: assert property (o_high_phase_valid |->
		o_low_phase_valid && o_high_phase == o_low_phase) else $error("phase");
	a_low_only: assert property ($past(o_output_mode_select) == 2'h3 |->
		!o_high_phase_valid && !o_high_period_valid) else $error("low only");
	a_period_pair: assert property (o_high_period_valid |->
		o_low_period_valid && o_high_period == o_low_period) else $error("period");
	a_period_sel: assert property ($past(o_independent_time_base_select) |->
		o_low_period_valid && !o_low_phase_valid) else $error("period sel");
	a_edge_cause: assert property ($rose(o_blanking) |->
		$past(i_pwm_high_output) != $past(i_pwm_high_output, 2) ||
		$past(i_pwm_low_output) != $past(i_pwm_low_output, 2))
		else $error("blank without edge");
	// the mask may only act while a blanking sample was taken
	a_fault_pass: assert property (!$past(o_blanking) |->
		o_fault == $past(i_fault)) else $error("fault lost");
	a_limit_pass: assert property (!$past(o_blanking) |->
		o_current_limit == $past(i_current_limit)) else $error("limit lost");
	cover property ($rose(o_blanking));
	cover property (o_blanking && i_fault);
	cover property (o_high_period_valid);
	cover property (o_low_phase_valid && !o_high_phase_valid);
endmodule
bind pwmpb_top pwmpb_sva pwmpb_sva_inst (
	.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_pwm_high_output(i_pwm_high_output),
	.i_pwm_low_output(i_pwm_low_output), .i_fault(i_fault),
	.o_fault(o_fault), .i_current_limit(i_current_limit),
	.o_current_limit(o_current_limit), .o_blanking(o_blanking),
	.o_independent_time_base_select(o_independent_time_base_select),
	.o_output_mode_select(o_output_mode_select),
	.o_high_phase(o_high_phase), .o_low_phase(o_low_phase),
	.o_high_period(o_high_period), .o_low_period(o_low_period),
	.o_high_phase_valid(o_high_phase_valid),
	.o_low_phase_valid(o_low_phase_valid),
	.o_high_period_valid(o_high_period_valid),
	.o_low_period_valid(o_low_period_valid)
);

// ### pwmpb_top.sv
`include "pwmpb_regs.svh"
module pwmpb_top (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_pwm_high_output,
	input wire logic i_pwm_low_output,
	input wire logic i_fault,
	input wire logic i_current_limit,
	output logic o_fault,
	output logic o_current_limit,
	output logic o_blanking,
	output logic o_independent_time_base_select,
	output logic [1:0] o_output_mode_select,
	output logic [15:0] o_high_phase,
	output logic [15:0] o_low_phase,
	output logic [15:0] o_high_period,
	output logic [15:0] o_low_period,
	output logic o_high_phase_valid,
	output logic o_low_phase_valid,
	output logic o_high_period_valid,
	output logic o_low_period_valid
);
	// ==========================================
	// reset release
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic nrst;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign nrst = rst_sync_reg;

	// ==========================================
	// registers
	logic [15:0] phase_or_period_value_reg;
	logic [15:0] edge_blanking_control_reg;
	logic [15:0] generator_control_reg;

	// ==========================================
	// write decode
	logic wr_phase;
	logic wr_blank;
	logic wr_ctrl;

	// unmapped offsets fall through every branch, so their writes are lost
	always_comb begin
		wr_phase = 1'b0;
		wr_blank = 1'b0;
		wr_ctrl = 1'b0;
		if (!i_wr) begin
			wr_phase = 1'b0;
		end else if (i_addr == `PWMPB_ADDR_PHASE) begin
			wr_phase = 1'b1;
		end else if (i_addr == `PWMPB_ADDR_BLANK) begin
			wr_blank = 1'b1;
		end else if (i_addr == `PWMPB_ADDR_CTRL) begin
			wr_ctrl = 1'b1;
		end
	end

	// whole-word writes only; the port has no byte lanes, so a word is all
	// that can arrive
	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			phase_or_period_value_reg <= `PWMPB_PHASE_RST;
		end else if (wr_phase) begin
			phase_or_period_value_reg <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			edge_blanking_control_reg <= `PWMPB_BLANK_RST;
		end else if (wr_blank) begin
			edge_blanking_control_reg <= i_wdata & `PWMPB_BLANK_MASK;
		end
	end

	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			generator_control_reg <= `PWMPB_CTRL_RST;
		end else if (wr_ctrl) begin
			generator_control_reg <= i_wdata & `PWMPB_CTRL_MASK;
		end
	end

	// ==========================================
	// value routing
	logic independent_time_base_select;
	pwmpb_pkg::pwmpb_mode_type mode;
	logic high_used;
	logic high_phase_sel;
	logic low_phase_sel;
	logic high_period_sel;
	logic low_period_sel;

	assign independent_time_base_select = generator_control_reg[`PWMPB_ITB_BIT];
	assign mode = pwmpb_pkg::pwmpb_mode_type'(
		generator_control_reg[`PWMPB_MODE_MSB:`PWMPB_MODE_LSB]);
	assign o_independent_time_base_select = independent_time_base_select;
	assign o_output_mode_select = mode;

	// the paired modes share one value across both outputs; in true
	// independent mode the high output keeps its own setting elsewhere
	always_comb begin
		case (mode)
			pwmpb_pkg::PWMPB_MODE_COMPL: begin
				high_used = 1'b1;
			end
			pwmpb_pkg::PWMPB_MODE_REDUN: begin
				high_used = 1'b1;
			end
			pwmpb_pkg::PWMPB_MODE_PUSHPULL: begin
				high_used = 1'b1;
			end
			pwmpb_pkg::PWMPB_MODE_INDEP: begin
				high_used = 1'b0;
			end
			default: begin
				high_used = 1'b0;
			end
		endcase
	end

	assign high_phase_sel = !independent_time_base_select && high_used;
	assign low_phase_sel = !independent_time_base_select;
	assign high_period_sel = independent_time_base_select && high_used;
	assign low_period_sel = independent_time_base_select;

	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			o_high_phase <= 16'h0000;
			o_low_phase <= 16'h0000;
			o_high_period <= 16'h0000;
			o_low_period <= 16'h0000;
			o_high_phase_valid <= 1'b0;
			o_low_phase_valid <= 1'b0;
			o_high_period_valid <= 1'b0;
			o_low_period_valid <= 1'b0;
		end else begin
			o_high_phase_valid <= high_phase_sel;
			o_low_phase_valid <= low_phase_sel;
			o_high_period_valid <= high_period_sel;
			o_low_period_valid <= low_period_sel;
			o_high_phase <= high_phase_sel ?
				phase_or_period_value_reg : 16'h0000;
			o_low_phase <= low_phase_sel ?
				phase_or_period_value_reg : 16'h0000;
			o_high_period <= high_period_sel ?
				phase_or_period_value_reg : 16'h0000;
			o_low_period <= low_period_sel ?
				phase_or_period_value_reg : 16'h0000;
		end
	end

	// ==========================================
	// edge detection
	// bit 0 follows the high output, bit 1 the low output
	logic [1:0] pin_now;
	logic [1:0] rise_en;
	logic [1:0] fall_en;
	wire logic [1:0] pin_trig;
	logic trigger;

	assign pin_now = {i_pwm_low_output, i_pwm_high_output};
	assign rise_en = {edge_blanking_control_reg[`PWMPB_LRISE_BIT],
		edge_blanking_control_reg[`PWMPB_HRISE_BIT]};
	assign fall_en = {edge_blanking_control_reg[`PWMPB_LFALL_BIT],
		edge_blanking_control_reg[`PWMPB_HFALL_BIT]};

	// the last sample resets low, the idle level of both outputs; a pin
	// already high at release therefore reads as one rising edge
	for (genvar g = 0; g < 2; g++) begin : g_edge
		logic prev_reg;

		always_ff @(posedge i_mclk or negedge nrst) begin
			if (!nrst) begin
				prev_reg <= 1'b0;
			end else begin
				prev_reg <= pin_now[g];
			end
		end

		assign pin_trig[g] =
			(rise_en[g] && pin_now[g] && !prev_reg) ||
			(fall_en[g] && !pin_now[g] && prev_reg);
	end

	assign trigger = |pin_trig;

	// ==========================================
	// blanking counter
	// duration field up to 127 steps, each rounded up to whole cycles
	localparam int CNT_W = 9;
	logic [6:0] duration;
	logic [CNT_W-1:0] blank_len;
	logic [CNT_W-1:0] count_reg;
	pwmpb_pkg::pwmpb_state_type state_reg;
	logic load;

	assign duration =
		edge_blanking_control_reg[`PWMPB_DUR_MSB:`PWMPB_DUR_LSB];
	assign blank_len = CNT_W'(duration * `PWMPB_STEP_CYC);
	// a zero-length field leaves every edge without effect
	assign load = trigger && (blank_len != '0);

	// a new edge during blanking restarts the full interval
	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= pwmpb_pkg::PWMPB_IDLE;
			count_reg <= '0;
		end else begin
			case (state_reg)
				pwmpb_pkg::PWMPB_IDLE: begin
					if (load) begin
						state_reg <= pwmpb_pkg::PWMPB_BLANKING;
						count_reg <= blank_len;
					end
				end
				pwmpb_pkg::PWMPB_BLANKING: begin
					if (load) begin
						count_reg <= blank_len;
					end else if (count_reg <= CNT_W'(1)) begin
						state_reg <= pwmpb_pkg::PWMPB_IDLE;
						count_reg <= '0;
					end else begin
						count_reg <= count_reg - CNT_W'(1);
					end
				end
				default: begin
					state_reg <= pwmpb_pkg::PWMPB_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// masked inputs
	logic blanking;

	assign blanking = (state_reg == pwmpb_pkg::PWMPB_BLANKING);
	assign o_blanking = blanking;

	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			o_fault <= 1'b0;
			o_current_limit <= 1'b0;
		end else begin
			o_fault <= i_fault && !(blanking &&
				edge_blanking_control_reg[`PWMPB_FLTEN_BIT]);
			o_current_limit <= i_current_limit && !(blanking &&
				edge_blanking_control_reg[`PWMPB_CLEN_BIT]);
		end
	end

	// ==========================================
	// read port
	logic [15:0] rd_next;

	always_comb begin
		if (i_addr == `PWMPB_ADDR_PHASE) begin
			rd_next = phase_or_period_value_reg;
		end else if (i_addr == `PWMPB_ADDR_BLANK) begin
			rd_next = edge_blanking_control_reg;
		end else if (i_addr == `PWMPB_ADDR_CTRL) begin
			rd_next = generator_control_reg;
		end else if (i_addr == `PWMPB_ADDR_STAT) begin
			rd_next = {7'h00, count_reg};
		end else begin
			rd_next = 16'h0000;
		end
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge i_mclk or negedge nrst) begin
		if (!nrst) begin
			o_rdata <= 16'h0000;
		end else begin
			o_rdata <= i_rd ? rd_next : 16'h0000;
		end
	end
endmodule

// ### pwmpb_top_tb.sv
// ========
// bench
module pwmpb_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int S = 2;
	logic i_mclk = 1'h0, i_nrst = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
	logic i_pwm_high_output = 1'h0, i_pwm_low_output = 1'h0;
	logic i_fault, i_current_limit, o_fault, o_current_limit, o_blanking;
	logic o_independent_time_base_select, o_high_phase_valid;
	logic o_low_phase_valid, o_high_period_valid, o_low_period_valid;
	logic [1:0] o_output_mode_select;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000, o_rdata, o_high_phase, o_low_phase;
	logic [15:0] o_high_period, o_low_period, v;
	logic [15:0] bv [7] = '{16'h8818, 16'h4428, 16'h2038, 16'h1008,
		16'h8C00, 16'h8000, 16'h8FF8};
	logic [6:0] bs = 7'h0C;
	int n_mismatch = 0, compares = 0;
	integer seed = 32'h6702;
	always #20 i_mclk = ~i_mclk;
	// one sense model feeds both inputs so only the enables differ
	assign i_current_limit = i_fault;
	pwmpb_top pwmpb_top_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_pwm_high_output(i_pwm_high_output),
		.i_pwm_low_output(i_pwm_low_output), .i_fault(i_fault),
		.i_current_limit(i_current_limit), .o_fault(o_fault),
		.o_current_limit(o_current_limit), .o_blanking(o_blanking),
		.o_independent_time_base_select(o_independent_time_base_select),
		.o_output_mode_select(o_output_mode_select),
		.o_high_phase(o_high_phase), .o_low_phase(o_low_phase),
		.o_high_period(o_high_period), .o_low_period(o_low_period),
		.o_high_phase_valid(o_high_phase_valid),
		.o_low_phase_valid(o_low_phase_valid),
		.o_high_period_valid(o_high_period_valid),
		.o_low_period_valid(o_low_period_valid));
	pwmpb_stage #(.SPIKE(S)) pwmpb_stage_inst (.i_clk(i_mclk),
		.i_high(i_pwm_high_output), .o_spike(i_fault));
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [15:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_mclk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		#1;
		if (!w)
			chk("rdata", d, o_rdata);
	endtask
	task automatic final_report;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic blank_case(logic [15:0] val, logic sel);
		logic lvl;
		int eb, ef, ec, nb = 0, nf = 0, nc = 0;
		bus(1'h1, 4'h2, val);
		lvl = sel ? !i_pwm_low_output : !i_pwm_high_output;
		eb = val[(sel ? 13 : 15) - (lvl ? 0 : 1)] ? int'(val[9:3]) : 0;
		ef = (!sel && lvl) ? S : 0;
		ec = (val[10] && eb >= S) ? 0 : ef;
		ef = (val[11] && eb >= S) ? 0 : ef;
		@(posedge i_mclk);
		if (sel)
			i_pwm_low_output <= lvl;
		else
			i_pwm_high_output <= lvl;
		repeat (140) begin
			@(posedge i_mclk);
			#1;
			nb += int'(o_blanking === 1'h1);
			nf += int'(o_fault === 1'h1);
			nc += int'(o_current_limit === 1'h1);
		end
		chk("blank", 16'(eb), 16'(nb));
		chk("fault", 16'(ef), 16'(nf));
		chk("limit", 16'(ec), 16'(nc));
	endtask
	initial begin
		repeat (16) @(posedge i_mclk);
		i_nrst <= 1'h1;
		repeat (3) @(posedge i_mclk);
		bus(1'h0, 4'h0, 16'h0000);
		bus(1'h0, 4'h2, 16'h0000);
		bus(1'h1, 4'h2, 16'hFFFF);
		bus(1'h0, 4'h2, 16'hFFF8);
		bus(1'h1, 4'h9, 16'hFFFF);
		bus(1'h0, 4'h9, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			v = 16'($random(seed)) | 16'h0010;
			bus(1'h1, 4'h0, v);
			bus(1'h1, 4'h4, 16'(i));
			repeat (2) @(posedge i_mclk);
			#1;
			chk("hph", !i[2] && i[1:0] != 3 ? v : 16'h0, o_high_phase);
			chk("lph", !i[2] ? v : 16'h0, o_low_phase);
			chk("hpr", i[2] && i[1:0] != 3 ? v : 16'h0, o_high_period);
			chk("lpr", i[2] ? v : 16'h0, o_low_period);
			chk("itb", 16'(i[2]), 16'(o_independent_time_base_select));
			chk("mode", 16'(i[1:0]), 16'(o_output_mode_select));
			bus(1'h0, 4'h0, v);
		end
		bus(1'h0, 4'h4, 16'h0007);
		foreach (bv[k])
			blank_case(bv[k], bs[k]);
		bus(1'h0, 4'h6, 16'h0000);
		final_report;
	end
	initial begin
		#(40 * 5000);
		n_mismatch++;
		final_report;
	end
endmodule
